// ===== rtl/pwdr_consts.vh
// How it works
// - Upper six bits and lower eight bits form one 14-bit duty value; both halves are write-only, the value reads back at the duty register.
// - The 14-bit value sets high time within each generated waveform cycle.
// - An upper write latches its six bits and the staged lower byte into the generator.
// - Reading either data register returns 32'h0000_00ff.
// - Reset loads the pair with the low 14 bits of 16'hc000, all zero; unused upper bits of the duty readback read as zero.
`ifndef PWDR_CONSTS_VH
`define PWDR_CONSTS_VH
`define PWDR_ADDR_UPPER   12'h000
`define PWDR_ADDR_LOWER   12'h004
`define PWDR_ADDR_DUTY    12'h008
`define PWDR_ADDR_CTRL    12'h00c
`define PWDR_RESET_VALUE  16'hc000
`define PWDR_READ_ONES    32'h0000_00ff
`define PWDR_UPPER_LSB    8
`define PWDR_UPPER_W      6
`define PWDR_LOWER_W      8
`define PWDR_DUTY_W       14
`define PWDR_PERIOD_DEF   14'h3fff
`define PWDR_CTRL_EN_BIT  0
`define PWDR_CTRL_PEND_BIT 1
`endif

// ===== rtl/pwdr_top.v
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "pwdr_consts.vh"
module pwdr_top #(
    parameter ADDR_W = 12
) (
    // Clock and reset
    input  wire              clk,
    input  wire              sys_rst,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    input  wire [3:0]        pstrb,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // Waveform output
    output reg               pwm_out,
    output reg  [13:0]       duty_value
);

    // One-hot handshake states
    localparam [3:0] ST_IDLE   = 4'b0001;
    localparam [3:0] ST_SETUP  = 4'b0010;
    localparam [3:0] ST_ANSWER = 4'b0100;
    localparam [3:0] ST_DRAIN  = 4'b1000;

    // Handshake
    reg  [3:0]  state_r;
    reg  [3:0]  state_nxt;
    reg         ready_nxt;
    reg         err_nxt;
    reg  [31:0] rdata_nxt;

    // Address decode
    reg         sel_upper;
    reg         sel_lower;
    reg         sel_duty;
    reg         sel_ctrl;
    reg         sel_none;

    // Register storage
    reg  [7:0]  lower_stage_r;
    reg  [7:0]  lower_stage_nxt;
    reg  [13:0] duty_r;
    reg  [13:0] duty_nxt;
    reg         pend_r;
    reg         pend_nxt;
    reg         run_r;
    reg         run_nxt;

    // Readback words
    reg  [31:0] duty_word;
    reg  [31:0] ctrl_word;

    // Waveform
    reg  [13:0] cnt_r;
    reg  [13:0] cnt_nxt;
    reg         pwm_nxt;

    // Constants at their working widths
    wire [15:0] reset_word  = `PWDR_RESET_VALUE;
    wire [13:0] reset_duty  = reset_word[`PWDR_DUTY_W-1:0];
    wire [13:0] period_last = `PWDR_PERIOD_DEF;
    wire [31:0] read_ones   = `PWDR_READ_ONES;

    // Bus qualifiers
    wire        in_setup  = psel && !penable;
    wire        in_access = psel && penable;
    // Writes land on the edge where pready is seen high, so the master sees them at once
    wire        wr_commit = pready && in_access && pwrite && pstrb[0];
    wire        wr_upper  = wr_commit && sel_upper;
    wire        wr_lower  = wr_commit && sel_lower;
    wire        wr_ctrl   = wr_commit && sel_ctrl;

    // Address decode
    always @* begin
        sel_upper = 1'b0;
        sel_lower = 1'b0;
        sel_duty  = 1'b0;
        sel_ctrl  = 1'b0;
        sel_none  = 1'b0;
        if (paddr == `PWDR_ADDR_UPPER) begin
            sel_upper = 1'b1;
        end else if (paddr == `PWDR_ADDR_LOWER) begin
            sel_lower = 1'b1;
        end else if (paddr == `PWDR_ADDR_DUTY) begin
            sel_duty = 1'b1;
        end else if (paddr == `PWDR_ADDR_CTRL) begin
            sel_ctrl = 1'b1;
        end else begin
            sel_none = 1'b1;
        end
    end

    // One wait state: answer one cycle after the access phase starts
    always @* begin
        state_nxt = ST_IDLE;
        case (state_r)
            ST_IDLE: begin
                if (in_access) begin
                    state_nxt = ST_ANSWER;
                end else if (in_setup) begin
                    state_nxt = ST_SETUP;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_SETUP: begin
                if (in_access) begin
                    state_nxt = ST_ANSWER;
                end else if (in_setup) begin
                    state_nxt = ST_SETUP;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ANSWER: begin
                state_nxt = ST_DRAIN;
            end
            ST_DRAIN: begin
                // Access still held after the answer: never answer twice
                if (in_access) begin
                    state_nxt = ST_DRAIN;
                end else if (in_setup) begin
                    state_nxt = ST_SETUP;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @* begin
        duty_word = 32'h0000_0000;
        duty_word[`PWDR_DUTY_W-1:0] = duty_r;
    end

    always @* begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`PWDR_CTRL_EN_BIT]   = run_r;
        ctrl_word[`PWDR_CTRL_PEND_BIT] = pend_r;
    end

    always @* begin
        ready_nxt = 1'b0;
        err_nxt   = 1'b0;
        rdata_nxt = 32'h0000_0000;
        if (state_nxt == ST_ANSWER) begin
            ready_nxt = 1'b1;
            err_nxt   = sel_none;
            if (!pwrite) begin
                if (sel_upper || sel_lower) begin
                    rdata_nxt = read_ones;
                end else if (sel_duty) begin
                    rdata_nxt = duty_word;
                end else if (sel_ctrl) begin
                    rdata_nxt = ctrl_word;
                end else begin
                    rdata_nxt = 32'h0000_0000;
                end
            end
        end
    end

    always @* begin
        lower_stage_nxt = lower_stage_r;
        if (wr_lower) begin
            lower_stage_nxt = pwdata[`PWDR_LOWER_W-1:0];
        end
    end

    // Pending flag: a lower and an upper write never share one edge
    always @* begin
        pend_nxt = pend_r;
        if (wr_lower) begin
            pend_nxt = 1'b1;
        end else if (wr_upper) begin
            pend_nxt = 1'b0;
        end
    end

    // Upper write carries the staged byte along
    always @* begin
        duty_nxt = duty_r;
        if (wr_upper) begin
            duty_nxt[`PWDR_DUTY_W-1:`PWDR_UPPER_LSB] = pwdata[`PWDR_UPPER_W-1:0];
            duty_nxt[`PWDR_UPPER_LSB-1:0]            = lower_stage_r;
        end
    end

    always @* begin
        run_nxt = run_r;
        if (wr_ctrl) begin
            run_nxt = pwdata[`PWDR_CTRL_EN_BIT];
        end
    end

    // Fixed period; new duty takes hold at once, a glitch-free reload was traded for size
    always @* begin
        if (cnt_r == period_last) begin
            cnt_nxt = 14'h0000;
        end else begin
            cnt_nxt = cnt_r + 14'h0001;
        end
    end

    always @* begin
        pwm_nxt = run_r && (cnt_r < duty_r);
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
        end else begin
            pready <= ready_nxt;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= err_nxt;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= rdata_nxt;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            lower_stage_r <= reset_duty[`PWDR_LOWER_W-1:0];
        end else begin
            lower_stage_r <= lower_stage_nxt;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            duty_r <= reset_duty;
        end else begin
            duty_r <= duty_nxt;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            run_r <= 1'b1;
        end else begin
            run_r <= run_nxt;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= 14'h0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= pwm_nxt;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            duty_value <= reset_duty;
        end else begin
            duty_value <= duty_r;
        end
    end

endmodule

// ===== tb/pwdr_top_assertions.sv
`timescale 1ns/1ns
module pwdr_chk #(parameter ADDR_W = 12) (
    input wire              clk, sys_rst, pwrite, pready, pwm_out,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata, prdata,
    input wire [13:0]       duty_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_RD: assert property (pready && !pwrite && paddr < 8 |-> prdata == 32'hff)
        else $error("read not ones");
    AST_UP: assert property (pready && pwrite && paddr == 0 |=> ##1 duty_value[13:8] == $past(pwdata[5:0], 2))
        else $error("upper not latched");
    AST_HOLD: assert property (!$past(pready && pwrite && paddr == 0, 2) |-> $stable(duty_value))
        else $error("duty moved");
    AST_RST: assert property ($fell(sys_rst) |-> duty_value == 0 && !pwm_out)
        else $error("bad reset");
    AST_PWM: assert property ((duty_value == 0) [*3] |-> !pwm_out)
        else $error("pwm high");
    AST_LOW: assert property (pready && pwrite && paddr == 4 |=> ##1 $stable(duty_value))
        else $error("lower write moved duty");
    cover property (pready && pwrite && paddr == 0);
    cover property (pready && !pwrite);
    cover property (pwm_out);
endmodule
bind pwdr_top pwdr_chk #(.ADDR_W(ADDR_W)) i_pwdr_chk (.clk(clk), .sys_rst(sys_rst), .pwrite(pwrite),
    .pready(pready), .pwm_out(pwm_out), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .duty_value(duty_value));

// ===== tb/pwdr_test.sv
`timescale 1ns/1ns
module pwm_width_data_register_test;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, pwm_out;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        err;
    logic [13:0] duty_value;
    int n_errors = 0, check_count = 0, cyc = 0;
    pwdr_top i_pwdr_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_out(pwm_out), .duty_value(duty_value));
    initial forever #5 clk = ~clk;
    // Hang guard
    always @(posedge clk) if (++cyc > 40000) begin
        n_errors++;
        conclude;
    end
    task chk(input string s, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask
    // Request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task duty(input logic [13:0] e);
        repeat (2) @(posedge clk);
        chk("duty", 32'(e), 32'(duty_value));
    endtask
    task t_write;
        apb(1, 12'h004, 32'ha5);
        apb(1, 12'h000, 32'h2b);
        duty(14'h2ba5);
        apb(1, 12'h000, 32'h01);
        duty(14'h01a5);
        $display("write done");
    endtask
    task t_read;
        apb(0, 12'h000, 0);
        chk("rd_upper", 32'hff, rd);
        chk("err_upper", 0, 32'(err));
        apb(1, 12'h010, 32'h3f);
        chk("err_unmapped", 1, 32'(err));
        duty(14'h01a5);
        apb(0, 12'h004, 0);
        chk("rd_lower", 32'hff, rd);
        $display("read done");
    endtask
    task t_pwm;
        int n;
        apb(1, 12'h004, 32'h23);
        apb(1, 12'h000, 32'h01);
        apb(0, 12'h008, 0);
        chk("rd_duty", 32'h123, rd);
        n = 0;
        repeat (16384) begin
            @(posedge clk);
            if (pwm_out === 1'b1) n++;
        end
        chk("pwm_high", 32'h123, n);
        apb(1, 12'h00c, 0);
        n = 0;
        repeat (16384) begin
            @(posedge clk);
            if (pwm_out !== 1'b0) n++;
        end
        chk("pwm_stopped", 0, n);
        $display("pwm done");
    endtask
    task t_reset;
        sys_rst <= 1;
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk);
        chk("rst_duty_mid", 0, 32'(duty_value));
        chk("rst_pwm", 0, 32'(pwm_out));
        apb(1, 12'h000, 32'h02);
        duty(14'h0200);
        $display("reset done");
    endtask
    task conclude;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk);
        chk("rst_duty", 0, 32'(duty_value));
        t_write;
        t_read;
        t_pwm;
        t_reset;
        conclude;
    end
endmodule
